// File: core/srp_serial_register_port.sv
// Serial slave port with the register map and conversion ready signalling.
// Assumes the converter runs on the same clock and reports each result with a pulse.
`timescale 1ns/100ps
// Notes on behaviour
// - Frames are 24 bits, MSB first, while selected
// - Address byte first, then sixteen data bits
// - Only frame bits 20 to 16 address
// - Bit 21 low writes data at frame end
// - Bit 21 high shifts data out from rise nine
// - Read frame also stores incoming data bits
// - Select high resets port, clock ignored
// - Serial input sampled on falling clock edges
// - Serial input is never driven here
// - Continuous mode gives 8 us ready pulse
// - Single-shot completion drives ready low
// - Single-shot returns to power-down after conversion
// - Result register read-only, full 16 bits
// - Control register field layout and defaults
// - Supply watch needs both enable bits
// - Power-down write ignored while converting
// - Mode bit reads zero while converting
module srp_serial_register_port (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   port_select_n,
  input  wire logic                   serial_clock,
  input  wire logic                   serial_in_line,
  input  wire logic                   conversion_done,
  input  wire logic [15:0]            conversion_value,
  output logic                        serial_out_line,
  output logic                        serial_out_en,
  output logic                        ready_n,
  output logic                        converter_run,
  output srp_pkg::srp_conv_cfg_t      conv_cfg,
  output srp_pkg::srp_power_t         power_cfg
);

  logic [2:0]                   pin_level;
  logic                         sel_n;
  logic                         sck;
  logic                         din;
  logic                         sck_prev;
  logic [4:0]                   fall_cnt;
  logic [4:0]                   rise_cnt;
  logic [22:0]                  shift_in;
  logic                         is_read;
  logic [15:0]                  rd_shift;
  logic                         busy;
  logic [srp_pkg::PULSE_W-1:0]  pulse_cnt;
  logic [15:0]                  regs [0:31];
  logic                         next_sck_prev;
  logic [4:0]                   next_fall_cnt;
  logic [4:0]                   next_rise_cnt;
  logic [22:0]                  next_shift_in;
  logic                         next_is_read;
  logic [15:0]                  next_rd_shift;
  logic                         next_sdo;
  logic                         next_busy;
  logic                         next_ready_n;
  logic [srp_pkg::PULSE_W-1:0]  next_pulse_cnt;
  logic [15:0]                  next_regs [0:31];
  logic                         sck_fall;
  logic                         sck_rise;
  logic [7:0]                   addr_byte;
  logic [23:0]                  frame_word;
  logic                         commit;
  logic [4:0]                   wr_addr;
  logic [15:0]                  wr_data;

  // Pins come from the master's domain; select idles high
  srp_pin_sync #(
    .WIDTH     (3),
    .RST_LEVEL (3'h4)
  ) u_pin_sync (
    .clock     (clock),
    .rst       (rst),
    .pin_raw   ({port_select_n, serial_clock, serial_in_line}),
    .pin_level (pin_level)
  );

  assign sel_n      = pin_level[2];
  assign sck        = pin_level[1];
  assign din        = pin_level[0];
  assign sck_fall   = sck_prev & ~sck;
  assign sck_rise   = ~sck_prev & sck;
  assign addr_byte  = {shift_in[6:0], din};
  assign frame_word = {shift_in, din};
  assign wr_addr    = frame_word[srp_pkg::ADDR_HI:srp_pkg::ADDR_LO];
  assign wr_data    = frame_word[srp_pkg::DATA_BITS-1:0];

  // Addresses that hold a register; the rest read as zero
  function automatic logic mapped(input logic [4:0] a);
    case (a)
      srp_pkg::ADDR_RESULT, srp_pkg::ADDR_CTRL, srp_pkg::ADDR_MISC_A, srp_pkg::ADDR_MISC_B,
      srp_pkg::ADDR_POWER, srp_pkg::ADDR_ISW, srp_pkg::ADDR_VSENSE, srp_pkg::ADDR_QDEMOD,
      srp_pkg::ADDR_LOADC, srp_pkg::ADDR_EXFREQ, srp_pkg::ADDR_POWER2, srp_pkg::ADDR_ROUTE,
      srp_pkg::ADDR_MISC_C: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] reset_value(input logic [4:0] a);
    case (a)
      srp_pkg::ADDR_CTRL:   reset_value = srp_pkg::RST_CTRL;
      srp_pkg::ADDR_MISC_A: reset_value = srp_pkg::RST_MISC_A;
      srp_pkg::ADDR_MISC_B: reset_value = srp_pkg::RST_MISC_B;
      default:              reset_value = srp_pkg::RST_ZERO;
    endcase
  endfunction

  // Read view: control status bits reflect a running conversion
  function automatic logic [15:0] read_value(input logic [4:0] a, input logic [15:0] stored, input logic run);
    logic [15:0] v;
    v = mapped(a) ? stored : 16'h0000;
    if (a == srp_pkg::ADDR_CTRL) begin
      v[srp_pkg::CTRL_ONESHOT] = ~run;
      v[srp_pkg::CTRL_PD]      = stored[srp_pkg::CTRL_PD] & ~run;
    end
    read_value = v;
  endfunction

  // Next state of the serial engine, register file and ready logic
  always_comb begin
    next_sck_prev  = sck;
    next_fall_cnt  = fall_cnt;
    next_rise_cnt  = rise_cnt;
    next_shift_in  = shift_in;
    next_is_read   = is_read;
    next_rd_shift  = rd_shift;
    next_sdo       = serial_out_line;
    next_busy      = busy;
    next_ready_n   = ready_n;
    next_pulse_cnt = pulse_cnt;
    commit         = 1'b0;
    for (int i = 0; i < 32; i++) begin
      next_regs[i] = regs[i];
    end
    if (sel_n) begin
      next_fall_cnt = 5'h00;
      next_rise_cnt = 5'h00;
      next_is_read  = 1'b0;
      next_sdo      = 1'b0;
    end else begin
      // Sample on falling edge, 24 per frame
      if (sck_fall && fall_cnt < srp_pkg::FRAME_BITS) begin
        next_shift_in = frame_word[22:0];
        next_fall_cnt = fall_cnt + 5'h01;
        if (fall_cnt == srp_pkg::ADDR_BITS - 5'h01) begin
          next_is_read  = addr_byte[srp_pkg::RW_POS];
          next_rd_shift = read_value(addr_byte[4:0], regs[addr_byte[4:0]], busy);
        end
        commit = (fall_cnt == srp_pkg::FRAME_BITS - 5'h01);
        // Frame end restarts count; select may stay low
        if (commit) begin
          next_fall_cnt = 5'h00;
          next_rise_cnt = 5'h00;
          next_is_read  = 1'b0;
        end
      end
      // Shift out on rising edges from the ninth
      if (sck_rise && rise_cnt < srp_pkg::FRAME_BITS) begin
        next_rise_cnt = rise_cnt + 5'h01;
        if (rise_cnt >= srp_pkg::ADDR_BITS && is_read) begin
          next_sdo      = rd_shift[15];
          next_rd_shift = {rd_shift[14:0], 1'b0};
        end
      end
    end
    // Store at frame end; reads store too; result is read-only
    if (commit && mapped(wr_addr) && wr_addr != srp_pkg::ADDR_RESULT) begin
      next_regs[wr_addr] = wr_data;
      if (wr_addr == srp_pkg::ADDR_CTRL) begin
        if (busy) begin
          // Mode and power-down held while converting
          next_regs[wr_addr][srp_pkg::CTRL_ONESHOT] = regs[wr_addr][srp_pkg::CTRL_ONESHOT];
          next_regs[wr_addr][srp_pkg::CTRL_PD]      = regs[wr_addr][srp_pkg::CTRL_PD];
        end else if (wr_data[srp_pkg::CTRL_ONESHOT] && wr_data[srp_pkg::CTRL_PD]) begin
          next_busy    = 1'b1;
          next_ready_n = 1'b1;
        end else if (!wr_data[srp_pkg::CTRL_PD]) begin
          next_ready_n = 1'b1;               // Leaving single-shot drops a held ready
        end
      end
    end
    // Continuous ready pulse countdown
    if (pulse_cnt != '0) begin
      next_pulse_cnt = pulse_cnt - 1'b1;
      if (pulse_cnt == 1) begin
        next_ready_n = 1'b1;
      end
    end
    if (conversion_done) begin
      next_regs[srp_pkg::ADDR_RESULT] = conversion_value;
      if (busy) begin
        next_busy    = 1'b0;
        next_ready_n = 1'b0;
      end else if (!regs[srp_pkg::ADDR_CTRL][srp_pkg::CTRL_PD]) begin
        next_ready_n   = 1'b0;
        next_pulse_cnt = srp_pkg::PULSE_W'(srp_pkg::READY_PULSE_CYC);
      end
    end
  end

  // Register all state; sync reset
  always_ff @(posedge clock) begin
    if (rst) begin
      sck_prev        <= 1'b0;
      fall_cnt        <= 5'h00;
      rise_cnt        <= 5'h00;
      shift_in        <= 23'h000000;
      is_read         <= 1'b0;
      rd_shift        <= 16'h0000;
      serial_out_line <= 1'b0;
      busy            <= 1'b0;
      ready_n         <= 1'b1;
      pulse_cnt       <= '0;
      for (int i = 0; i < 32; i++) begin
        regs[i] <= reset_value(5'(i));
      end
    end else begin
      sck_prev        <= next_sck_prev;
      fall_cnt        <= next_fall_cnt;
      rise_cnt        <= next_rise_cnt;
      shift_in        <= next_shift_in;
      is_read         <= next_is_read;
      rd_shift        <= next_rd_shift;
      serial_out_line <= next_sdo;
      busy            <= next_busy;
      ready_n         <= next_ready_n;
      pulse_cnt       <= next_pulse_cnt;
      for (int i = 0; i < 32; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  // Only the data output has an enable; off when deselected
  assign serial_out_en = ~sel_n & is_read & (rise_cnt > srp_pkg::ADDR_BITS);

  // Converter runs while free-running or during a single shot
  assign converter_run = busy | ~regs[srp_pkg::ADDR_CTRL][srp_pkg::CTRL_PD];

  assign conv_cfg.continuous           = ~regs[srp_pkg::ADDR_CTRL][srp_pkg::CTRL_PD];
  assign conv_cfg.input_pairing_select = regs[srp_pkg::ADDR_CTRL][srp_pkg::CTRL_PAIR_HI:srp_pkg::CTRL_PAIR_LO];
  assign conv_cfg.rate_select          = regs[srp_pkg::ADDR_CTRL][srp_pkg::CTRL_RATE_HI:srp_pkg::CTRL_RATE_LO];

  assign power_cfg.supply_watch_active = regs[srp_pkg::ADDR_POWER2][srp_pkg::WATCH_HI] &
                                         regs[srp_pkg::ADDR_POWER2][srp_pkg::WATCH_LO];
  assign power_cfg.excitation_dac_off  = regs[srp_pkg::ADDR_POWER][srp_pkg::PWR_DAC_OFF];
  assign power_cfg.chip_power_on       = regs[srp_pkg::ADDR_POWER][srp_pkg::PWR_CHIP_ON];
  assign power_cfg.impedance_chain_on  = regs[srp_pkg::ADDR_POWER][srp_pkg::PWR_IMP_ON];
  assign power_cfg.load_cell_chain_on  = regs[srp_pkg::ADDR_POWER][srp_pkg::PWR_LOAD_ON];

  // Checks kept beside the logic
  a_idle_output: assert property (@(posedge clock) disable iff (rst)
    sel_n |=> !serial_out_en && !serial_out_line)
    else $error("data output active while deselected");

  a_frame_cap: assert property (@(posedge clock) disable iff (rst)
    (sck_fall && !sel_n && fall_cnt == srp_pkg::FRAME_BITS - 5'h01) |=> fall_cnt == 5'h00 && !is_read)
    else $error("bit count not restarted at frame end");

  a_write_store: assert property (@(posedge clock) disable iff (rst)
    (commit && wr_addr == srp_pkg::ADDR_MISC_A) |=> regs[srp_pkg::ADDR_MISC_A] == $past(wr_data))
    else $error("written data not stored");

  a_result_ro: assert property (@(posedge clock) disable iff (rst)
    (!conversion_done) |=> regs[srp_pkg::ADDR_RESULT] == $past(regs[srp_pkg::ADDR_RESULT]))
    else $error("result changed without a conversion");

  a_read_start: assert property (@(posedge clock) disable iff (rst)
    (sck_rise && !sel_n && is_read && rise_cnt == srp_pkg::ADDR_BITS) |=> serial_out_en
      && serial_out_line == $past(rd_shift[15]))
    else $error("read data not driven at ninth rise");

  a_ready_pulse: assert property (@(posedge clock) disable iff (rst)
    (conversion_done && !busy && conv_cfg.continuous) |=> !ready_n
      && pulse_cnt == srp_pkg::PULSE_W'(srp_pkg::READY_PULSE_CYC))
    else $error("continuous ready pulse not started");

  a_pulse_end: assert property (@(posedge clock) disable iff (rst)
    (pulse_cnt == 1 && !conversion_done) |=> ready_n)
    else $error("ready pulse did not end on time");

  a_oneshot_done: assert property (@(posedge clock) disable iff (rst)
    (busy && conversion_done) |=> (!busy && !ready_n && !converter_run)[*2])
    else $error("single shot did not power down");

  a_pd_ignored: assert property (@(posedge clock) disable iff (rst)
    (busy && !conversion_done) |=> busy)
    else $error("busy cleared without conversion end");

  a_status_bit: assert property (@(posedge clock) disable iff (rst)
    (sck_fall && !sel_n && fall_cnt == srp_pkg::ADDR_BITS - 5'h01 && busy
      && addr_byte[4:0] == srp_pkg::ADDR_CTRL) |=> !rd_shift[15])
    else $error("mode bit reads idle while converting");

endmodule

// File: core/srp_pkg.sv
// Shared constants and carrier types for the serial register port.
// Assumes a single 125 MHz system clock and a synchronous active-high reset.
package srp_pkg;

  // Frame layout
  localparam logic [4:0] FRAME_BITS   = 5'h18;      // Bits in one frame
  localparam logic [4:0] ADDR_BITS    = 5'h08;      // Leading address byte
  localparam int         RW_POS       = 5;          // Direction bit inside address byte
  localparam int         ADDR_HI      = 20;         // Decoded address field in frame
  localparam int         ADDR_LO      = 16;
  localparam int         DATA_BITS    = 16;

  // Register offsets
  localparam logic [4:0] ADDR_RESULT  = 5'h00;
  localparam logic [4:0] ADDR_CTRL    = 5'h01;
  localparam logic [4:0] ADDR_MISC_A  = 5'h02;
  localparam logic [4:0] ADDR_MISC_B  = 5'h03;
  localparam logic [4:0] ADDR_POWER   = 5'h09;
  localparam logic [4:0] ADDR_ISW     = 5'h0A;
  localparam logic [4:0] ADDR_VSENSE  = 5'h0B;
  localparam logic [4:0] ADDR_QDEMOD  = 5'h0C;
  localparam logic [4:0] ADDR_LOADC   = 5'h0D;
  localparam logic [4:0] ADDR_EXFREQ  = 5'h0E;
  localparam logic [4:0] ADDR_POWER2  = 5'h0F;
  localparam logic [4:0] ADDR_ROUTE   = 5'h10;
  localparam logic [4:0] ADDR_MISC_C  = 5'h1A;

  // Values after reset
  localparam logic [15:0] RST_CTRL    = 16'h01C3;
  localparam logic [15:0] RST_MISC_A  = 16'h8000;
  localparam logic [15:0] RST_MISC_B  = 16'h7FFF;
  localparam logic [15:0] RST_ZERO    = 16'h0000;

  // Converter control fields
  localparam int CTRL_ONESHOT   = 15;
  localparam int CTRL_PAIR_HI   = 13;
  localparam int CTRL_PAIR_LO   = 11;
  localparam int CTRL_PD        = 7;
  localparam int CTRL_RATE_HI   = 6;
  localparam int CTRL_RATE_LO   = 4;

  // Power control fields
  localparam int PWR_DAC_OFF    = 3;
  localparam int PWR_CHIP_ON    = 2;
  localparam int PWR_IMP_ON     = 1;
  localparam int PWR_LOAD_ON    = 0;
  localparam int WATCH_HI       = 7;
  localparam int WATCH_LO       = 0;

  // Ready pulse timing
  localparam int CLK_PERIOD_NS     = 8;
  localparam int READY_PULSE_NS    = 8000;
  localparam int READY_PULSE_CYC   = (READY_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : READY_PULSE_NS / CLK_PERIOD_NS;
  localparam int PULSE_W           = $clog2(READY_PULSE_CYC + 1);

  typedef struct packed {
    logic       continuous;      // Converter free-running
    logic [2:0] input_pairing_select;
    logic [2:0] rate_select;
  } srp_conv_cfg_t;

  typedef struct packed {
    logic excitation_dac_off;
    logic chip_power_on;
    logic impedance_chain_on;
    logic load_cell_chain_on;
    logic supply_watch_active;
  } srp_power_t;

endpackage

// File: core/srp_pin_sync.sv
// Three-stage synchroniser for asynchronous pin inputs.
// A change is accepted once the second and third stages agree.
`timescale 1ns/100ps
module srp_pin_sync #(
  parameter int                 WIDTH     = 1,
  parameter logic [WIDTH-1:0]   RST_LEVEL = '0
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_raw,
  output logic      [WIDTH-1:0] pin_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // Hold the old level while the two later stages disagree
  always_comb begin
    next_level = (stage2 & stage3) | (pin_level & (stage2 | stage3));
  end

  // Stage one feeds stage two only, never the filter
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1    <= RST_LEVEL;
      stage2    <= RST_LEVEL;
      stage3    <= RST_LEVEL;
      pin_level <= RST_LEVEL;
    end else begin
      stage1    <= pin_raw;
      stage2    <= stage1;
      stage3    <= stage2;
      pin_level <= next_level;
    end
  end

endmodule

// File: verification/srp_master_model.sv
// Behavioural serial bus master that stands in for the external microcontroller.
// Assumes the system clock is shared so edges can be paced in whole system cycles.
`timescale 1ns/100ps
module srp_master_model #(
  parameter int HALF = 8                // System cycles per serial half period
) (
  input  wire logic clock,
  output logic      sel_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  logic keep_low = 1'b0;                // Bench sets this to leave select low after a frame

  // Idle pins at time zero: deselected, clock parked low
  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
    sdi   = 1'b0;
  end

  // One frame of nbits (24 for a whole frame); fewer bits model an abort
  task automatic frame(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
    rx = 24'h000000;
    // select low for the whole transfer
    @(posedge clock) sel_n <= 1'b0;
    repeat (HALF) @(posedge clock);
    // MSB first, address byte then data
    for (int i = 23; i > 23 - nbits; i--) begin
      @(posedge clock) sclk <= 1'b1;
      sdi <= tx[i];
      repeat (HALF - 1) @(posedge clock);
      // data stable across the falling edge; output read just before it
      rx[i] = sdo;
      @(posedge clock) sclk <= 1'b0;
      repeat (HALF - 1) @(posedge clock);
    end
    // clock stays low when idle; select may stay low
    @(posedge clock) sel_n <= !keep_low;
    sdi <= ~sdi;                        // Released line shows no stale bit
    repeat (HALF) @(posedge clock);
  endtask
endmodule

// File: verification/serial_register_port_tb.sv
// Self-checking bench for the serial register port.
// Assumes the master model file is compiled first and the design files before it.
`timescale 1ns/100ps
module serial_register_port_tb;
  typedef struct packed {
    logic        rd;
    logic [7:0]  abyte;
    logic [15:0] tx;
    logic [15:0] exp;
  } srp_row_t;

  logic                   clock = 1'b0;
  logic                   rst   = 1'b1;
  logic                   sel_n;
  logic                   sclk;
  logic                   sdi;
  logic                   conversion_done  = 1'b0;
  logic [15:0]            conversion_value = 16'h0000;
  logic                   serial_out_line;
  logic                   serial_out_en;
  logic                   ready_n;
  logic                   converter_run;
  srp_pkg::srp_conv_cfg_t conv_cfg;
  srp_pkg::srp_power_t    power_cfg;
  int                     bad_count = 0;
  int                     checks    = 0;
  logic [23:0]            rx;
  int                     n;

  // Reads also send their tx data; all but the 21, 5A5A and E2 reads get their own tx value back
  srp_row_t rows [18] = '{
    '{1'b1, 8'h22, 16'h8000, 16'h8000}, '{1'b1, 8'h23, 16'h7FFF, 16'h7FFF},
    '{1'b1, 8'h21, 16'h01C3, 16'h81C3}, '{1'b1, 8'h20, 16'h0000, 16'h0000},
    '{1'b0, 8'hC2, 16'h0000, 16'h0000}, '{1'b1, 8'h22, 16'h5A5A, 16'h0000},
    '{1'b1, 8'hE2, 16'h0000, 16'h5A5A}, '{1'b0, 8'h03, 16'hFFFF, 16'h0000},
    '{1'b1, 8'h23, 16'hFFFF, 16'hFFFF}, '{1'b0, 8'h1A, 16'h0030, 16'h0000},
    '{1'b1, 8'h3A, 16'h0030, 16'h0030}, '{1'b0, 8'h09, 16'h600F, 16'h0000},
    '{1'b1, 8'h29, 16'h600F, 16'h600F}, '{1'b0, 8'h0F, 16'h0081, 16'h0000},
    '{1'b1, 8'h2F, 16'h0081, 16'h0081}, '{1'b0, 8'h1F, 16'h1234, 16'h0000},
    '{1'b1, 8'h3F, 16'h0000, 16'h0000}, '{1'b0, 8'h00, 16'hABCD, 16'h0000}};

  // 125 MHz system clock
  always #4 clock = ~clock;

  srp_master_model #(.HALF(8)) u_master (
    .clock (clock),
    .sel_n (sel_n),
    .sclk  (sclk),
    .sdi   (sdi),
    .sdo   (serial_out_line)
  );

  srp_serial_register_port dut (
    .clock            (clock),
    .rst              (rst),
    .port_select_n    (sel_n),
    .serial_clock     (sclk),
    .serial_in_line   (sdi),
    .conversion_done  (conversion_done),
    .conversion_value (conversion_value),
    .serial_out_line  (serial_out_line),
    .serial_out_en    (serial_out_en),
    .ready_n          (ready_n),
    .converter_run    (converter_run),
    .conv_cfg         (conv_cfg),
    .power_cfg        (power_cfg)
  );

  // Compare and count; one line per mismatch
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Converter result strobe, one cycle wide
  task automatic strobe(input logic [15:0] val);
    @(posedge clock) conversion_done <= 1'b1;
    conversion_value <= val;
    @(posedge clock) conversion_done <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    // Table: reset values, writes, read-backs, ignored address bits, dropped writes
    foreach (rows[i]) begin
      // each read row also writes its tx data, except to the result and unmapped addresses
      u_master.frame({rows[i].abyte, rows[i].tx}, 24, rx);
      if (rows[i].rd)
        chk("read frame", {8'h00, rows[i].exp}, rx);
    end
    // Power fields and supply watch decode; init writes done above
    chk("power_cfg", 24'h00001F, {19'h00000, power_cfg});
    chk("out idle", 24'h000000, {22'h000000, serial_out_en, serial_out_line});
    // Aborted write frame leaves the register untouched
    u_master.frame({8'h1A, 16'hFFFF}, 10, rx);
    u_master.frame({8'h3A, 16'h0030}, 24, rx);
    chk("abort", 24'h000030, rx);
    // Select left low between frames; the bit count alone frames them
    u_master.keep_low = 1'b1;
    u_master.frame({8'h1A, 16'h1234}, 24, rx);
    u_master.keep_low = 1'b0;
    u_master.frame({8'h3A, 16'h0030}, 24, rx);
    chk("three wire", 24'h001234, rx);
    // Continuous mode, pairing 010, fastest rate
    u_master.frame({8'h01, 16'h5070}, 24, rx);
    chk("conv_cfg", 24'h000057, {17'h00000, conv_cfg});
    chk("run cont", 24'h000001, {23'h000000, converter_run});
    strobe(16'h1357);
    n = 0;
    while (ready_n !== 1'b0 && n < 5) begin
      @(posedge clock);
      n++;
    end
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ready_n === 1'b0 && n < 1100);
    chk("ready pulse", 24'h0003E8, n[23:0]);
    u_master.frame({8'h20, 16'h0000}, 24, rx);
    chk("result", 24'h001357, rx);
    // Single-shot start: both bits in one write; master picks the interval
    u_master.frame({8'h01, 16'hC0F0}, 24, rx);
    chk("run shot", 24'h000001, {23'h000000, converter_run});
    // Read-back while converting rewrites power-down as zero; it must not stick
    u_master.frame({8'h21, 16'h4070}, 24, rx);
    chk("busy view", 24'h004070, rx);
    strobe(16'h2468);
    repeat (3) @(posedge clock);
    chk("shot done", 24'h000000, {22'h000000, ready_n, converter_run});
    repeat (50) @(posedge clock);
    chk("ready held", 24'h000000, {23'h000000, ready_n});
    u_master.frame({8'h21, 16'h40F0}, 24, rx);
    chk("idle view", 24'h00C0F0, rx);
    u_master.frame({8'h20, 16'h0000}, 24, rx);
    chk("shot result", 24'h002468, rx);
    // Reset after the single shot drops the held ready and restores every default
    @(posedge clock) rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    chk("reset outs", 24'h008080,
        {8'h00, ready_n, converter_run, serial_out_en, serial_out_line, conv_cfg, power_cfg});
    repeat (4) @(posedge clock);
    u_master.frame({8'h22, 16'h0000}, 24, rx);
    chk("reset misc", 24'h008000, rx);
    tally_and_finish();
  end
endmodule
